// ===== core/sail_cfg.svh
// Register offsets, field positions and reset values of the SGMII management slice.
`ifndef SAIL_CFG_SVH
`define SAIL_CFG_SVH

`define SAIL_IDX_EXT_STATUS    8'h0F
`define SAIL_IDX_AN_IRQ_CTRL   8'h10
`define SAIL_IDX_LOOPBACK_CTRL 8'h11
`define SAIL_ADDR_EXT_STATUS    12'h03C
`define SAIL_ADDR_AN_IRQ_CTRL   12'h040
`define SAIL_ADDR_LOOPBACK_CTRL 12'h044
`define SAIL_ADDR_MGMT_CTRL     12'h048
`define SAIL_EXT_STATUS_VALUE  16'h8000
`define SAIL_BIT_IRQ_STATUS    1
`define SAIL_BIT_IRQ_ENABLE    0
`define SAIL_BIT_LOOPBACK_POS  0
`define SAIL_BIT_LOOPBACK_EN   14
`define SAIL_RST_IRQ_ENABLE    1'b1
`define SAIL_RST_LOOPBACK_EN   1'b0

`endif

// ===== core/sail_flag.sv
// One software-cleared event flag with a gating enable.
`timescale 1ns/1ps
`default_nettype none
module sail_flag (
  // Clock and reset.
  input  wire logic i_clk,
  input  wire logic i_nrst,
  // Control.
  input  wire logic i_enable,
  input  wire logic i_event,
  input  wire logic i_clear,
  // State.
  output logic      o_flag
);
  logic flag_q;

  // The event wins over a clear in the same cycle; a disabled flag is held low.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      flag_q <= 1'b0;
    end else if (!i_enable) begin
      flag_q <= 1'b0;
    end else if (i_event) begin
      flag_q <= 1'b1;
    end else if (i_clear) begin
      flag_q <= 1'b0;
    end
  end

  assign o_flag = flag_q;
endmodule
`default_nettype wire

// ===== core/sail_pkg.sv
// Types shared by the SGMII management slice.
package sail_pkg;
  typedef enum logic [1:0] {
    SAIL_LB_NONE   = 2'b00,
    SAIL_LB_MAC    = 2'b01,
    SAIL_LB_SERDES = 2'b10
  } sail_loopback_type;
endpackage

// ===== core/sail_regs.sv
// APB register slice: extended status, auto-negotiation interrupt and loopback location.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sail_cfg.svh"
module sail_regs #(
  parameter logic LOOPBACK_LOCATION_DEFAULT_PARAM = 1'b0
) (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // APB slave.
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Auto-negotiation engine.
  input  wire logic        i_an_complete,
  output logic             o_autoneg_done_irq_out,
  // Loopback steering.
  output logic             o_loopback_en,
  output logic             o_loopback_pos,
  output logic [1:0]       o_loopback_mode
);
  logic        irq_enable_q;
  logic        loopback_pos_q;
  logic        loopback_en_q;
  logic        irq_status;
  logic        wr_access;
  logic        rd_access;
  logic        lo_lane;
  logic        hi_lane;
  logic        mapped;
  logic        status_clear;
  logic [15:0] rd_word;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  assign wr_access = i_psel && i_penable && i_pwrite;
  assign rd_access = i_psel && i_penable && !i_pwrite;
  assign lo_lane   = i_pstrb[0];
  assign hi_lane   = i_pstrb[1];

  always_comb begin
    mapped = 1'b1;
    case (i_paddr)
      `SAIL_ADDR_EXT_STATUS,
      `SAIL_ADDR_AN_IRQ_CTRL,
      `SAIL_ADDR_LOOPBACK_CTRL,
      `SAIL_ADDR_MGMT_CTRL: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Interrupt enable, resets to one.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      irq_enable_q <= `SAIL_RST_IRQ_ENABLE;
    end else if (wr_access && lo_lane && i_paddr == `SAIL_ADDR_AN_IRQ_CTRL) begin
      irq_enable_q <= i_pwdata[`SAIL_BIT_IRQ_ENABLE];
    end
  end

  // A written zero clears the status, as does a low interrupt enable; a written one is ignored.
  assign status_clear = wr_access && lo_lane && i_paddr == `SAIL_ADDR_AN_IRQ_CTRL
                        && !i_pwdata[`SAIL_BIT_IRQ_STATUS];

  sail_flag u_irq_flag (
    .i_clk    (i_clk),
    .i_nrst   (i_nrst),
    .i_enable (irq_enable_q),
    .i_event  (i_an_complete),
    .i_clear  (status_clear),
    .o_flag   (irq_status)
  );

  assign o_autoneg_done_irq_out = irq_status;

  // Loopback location; reset value is the static interface setting.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      loopback_pos_q <= LOOPBACK_LOCATION_DEFAULT_PARAM;
    end else if (wr_access && lo_lane && i_paddr == `SAIL_ADDR_LOOPBACK_CTRL) begin
      loopback_pos_q <= i_pwdata[`SAIL_BIT_LOOPBACK_POS];
    end
  end

  // Loopback on/off lives in the management control word, bit 14.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      loopback_en_q <= `SAIL_RST_LOOPBACK_EN;
    end else if (wr_access && hi_lane && i_paddr == `SAIL_ADDR_MGMT_CTRL) begin
      loopback_en_q <= i_pwdata[`SAIL_BIT_LOOPBACK_EN];
    end
  end

  assign o_loopback_en  = loopback_en_q;
  assign o_loopback_pos = loopback_pos_q;

  // Position only picks the place; the enable decides whether to loop.
  always_comb begin
    if (!loopback_en_q) begin
      o_loopback_mode = sail_pkg::SAIL_LB_NONE;
    end else if (loopback_pos_q) begin
      o_loopback_mode = sail_pkg::SAIL_LB_SERDES;
    end else begin
      o_loopback_mode = sail_pkg::SAIL_LB_MAC;
    end
  end

  always_comb begin
    rd_word = 16'h0000;
    case (i_paddr)
      `SAIL_ADDR_EXT_STATUS: rd_word = `SAIL_EXT_STATUS_VALUE;
      `SAIL_ADDR_AN_IRQ_CTRL: begin
        rd_word[`SAIL_BIT_IRQ_STATUS] = irq_status;
        rd_word[`SAIL_BIT_IRQ_ENABLE] = irq_enable_q;
      end
      `SAIL_ADDR_LOOPBACK_CTRL: rd_word[`SAIL_BIT_LOOPBACK_POS] = loopback_pos_q;
      `SAIL_ADDR_MGMT_CTRL: rd_word[`SAIL_BIT_LOOPBACK_EN] = loopback_en_q;
      default: rd_word = 16'h0000;
    endcase
  end

  // Read data is registered during the setup cycle; access completes in one cycle.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      prdata_q <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      prdata_q <= {16'h0000, rd_word};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      pslverr_q <= 1'b0;
    end else if (i_psel && !i_penable) begin
      pslverr_q <= !mapped;
    end
  end

  assign o_prdata  = prdata_q;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && pslverr_q;
endmodule
`default_nettype wire

// ===== testbench/sail_regs_assertions.sv
// Port checker for the SGMII management slice.
`timescale 1ns/1ps
`default_nettype none
module sail_regs_chk #(parameter logic LOOPBACK_LOCATION_DEFAULT_PARAM = 1'b0) (
  // Slice ports.
  input wire logic        i_clk,
  input wire logic        i_nrst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0]  i_pstrb,
  input wire logic        i_an_complete,
  input wire logic [31:0] o_prdata,
  input wire logic        o_autoneg_done_irq_out,
  input wire logic        o_loopback_en,
  input wire logic        o_loopback_pos,
  input wire logic [1:0]  o_loopback_mode
);
  logic      en_q;
  wire logic acc = i_psel && i_penable;
  wire logic w40 = acc && i_pwrite && i_pstrb[0] && i_paddr == 12'h040;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence rd(a); acc && !i_pwrite && i_paddr == a; endsequence
  // Shadow of the interrupt enable, which no port shows.
  always_ff @(posedge i_clk) en_q <= !i_nrst ? 1'b1 : w40 ? i_pwdata[0] : en_q;
  ext_sts_a: assert property (rd(12'h03C) |-> o_prdata == 32'h00008000)
    else $error("ext status bad");
  irq_read_a: assert property (rd(12'h040) |->
    o_prdata == {30'h0, $past(o_autoneg_done_irq_out), $past(en_q)}) else $error("irq rd");
  irq_set_a: assert property (en_q && i_an_complete && !w40 |=> o_autoneg_done_irq_out)
    else $error("irq not set");
  irq_hold_a: assert property (o_autoneg_done_irq_out && !w40 |=> o_autoneg_done_irq_out)
    else $error("irq lost");
  irq_off_a: assert property (!en_q |=> !o_autoneg_done_irq_out) else $error("irq on");
  lb_mode_a: assert property (o_loopback_mode ==
    (o_loopback_en ? (o_loopback_pos ? 2'h2 : 2'h1) : 2'h0)) else $error("mode bad");
  lb_en_a: assert property (acc && i_pwrite && i_pstrb[1] && i_paddr == 12'h048 |=>
    o_loopback_en == $past(i_pwdata[14])) else $error("loopback enable bad");
  lb_rst_a: assert property ($rose(i_nrst) |->
    o_loopback_pos == LOOPBACK_LOCATION_DEFAULT_PARAM && !o_loopback_en) else $error("reset bad");
endmodule
bind sail_regs sail_regs_chk #(
  .LOOPBACK_LOCATION_DEFAULT_PARAM(LOOPBACK_LOCATION_DEFAULT_PARAM)
) chk (.i_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb,
  .i_an_complete, .o_prdata, .o_autoneg_done_irq_out, .o_loopback_en, .o_loopback_pos,
  .o_loopback_mode);
`default_nettype wire

// ===== testbench/sail_regs_tb_top.sv
// Directed bench for the SGMII management slice.
`timescale 1ns/1ps
`default_nettype none
module sail_regs_tb_top;
  logic        i_clk = 1'b0, i_nrst = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic        i_an_complete = 1'b0, o_pready, o_pslverr, o_autoneg_done_irq_out;
  logic        o_loopback_en, o_loopback_pos;
  logic [1:0]  o_loopback_mode;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rdata;
  logic [3:0]  i_pstrb = 4'hF;
  logic        perr;
  int          error_cnt = 0, checks_done = 0;
  always #5 i_clk = ~i_clk;
  sail_regs #(.LOOPBACK_LOCATION_DEFAULT_PARAM(1'b1)) uut (.i_clk, .i_nrst, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_prdata, .o_pready,
    .o_pslverr, .i_an_complete, .o_autoneg_done_irq_out, .o_loopback_en, .o_loopback_pos,
    .o_loopback_mode);
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1) @(posedge i_clk);
    rdata = o_prdata;
    perr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk("read", e, rdata);
  endtask
  task automatic pulse;
    i_an_complete <= 1'b1;
    @(posedge i_clk);
    i_an_complete <= 1'b0;
    @(posedge i_clk);
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(12'h03C, 32'h00008000);
    rd(12'h040, 32'h00000001);
    rd(12'h044, 32'h00000001);
    chk("slverr", 32'h0, {31'h0, perr});
    xfer(1'b1, 12'h03C, 32'hFFFFFFFF);
    rd(12'h03C, 32'h00008000);
    pulse();
    chk("irq", 32'h1, {31'h0, o_autoneg_done_irq_out});
    xfer(1'b1, 12'h040, 32'hFFFFFFFF);
    rd(12'h040, 32'h3);
    xfer(1'b1, 12'h040, 32'h1);
    rd(12'h040, 32'h1);
    pulse();
    i_pstrb <= 4'hE;
    xfer(1'b1, 12'h040, 32'h0);
    i_pstrb <= 4'hF;
    rd(12'h040, 32'h3);
    xfer(1'b1, 12'h040, 32'h0);
    pulse();
    rd(12'h040, 32'h0);
    chk("irq", 32'h0, {31'h0, o_autoneg_done_irq_out});
    chk("lb_en", 32'h0, {31'h0, o_loopback_en});
    xfer(1'b1, 12'h048, 32'h00004000);
    chk("mode", 32'h2, {30'h0, o_loopback_mode});
    chk("lb_en", 32'h1, {31'h0, o_loopback_en});
    xfer(1'b1, 12'h044, 32'h0);
    chk("mode", 32'h1, {30'h0, o_loopback_mode});
    chk("lb_pos", 32'h0, {31'h0, o_loopback_pos});
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(12'h040, 32'h00000001);
    rd(12'h044, 32'h00000001);
    chk("lb_en", 32'h0, {31'h0, o_loopback_en});
    chk("lb_pos", 32'h1, {31'h0, o_loopback_pos});
    rd(12'h100, 32'h0);
    chk("slverr", 32'h1, {31'h0, perr});
    wrap_up();
  end
  initial begin
    #20us;
    error_cnt++;
    wrap_up();
  end
endmodule
`default_nettype wire
